// ==== inc/rcs_pkg.sv ====
// Shared constants, types and helpers of the reset and clock source controller.
// Assumes a single core clock domain; pin-level inputs are synchronised inside the controller.
package rcs_pkg;

    // APB register byte offsets
    localparam logic [7:0] RCS_OFF_CONFIG = 8'h00;
    localparam logic [7:0] RCS_OFF_OSC = 8'h04;
    localparam logic [7:0] RCS_OFF_WDT = 8'h08;
    localparam logic [7:0] RCS_OFF_STATUS = 8'h0C;
    localparam logic [7:0] RCS_OFF_WDT_COUNT = 8'h10;

    // Configuration word: bit 0 reset pin, bits 3:1 high clock option, bit 4 noise filter, bits 7:5 divider
    typedef struct packed {
        logic [2:0] div_sel;
        logic noise_filter_en;
        logic [2:0] high_clock_option_select;
        logic reset_pin_en;
    } rcs_cfg_t;

    localparam rcs_cfg_t RCS_CFG_RESET = 8'h41;

    // High clock option codes
    localparam logic [2:0] RCS_HOPT_FAST_RC = 3'h0;
    localparam logic [2:0] RCS_HOPT_FAST_RC_RTC = 3'h1;
    localparam logic [2:0] RCS_HOPT_EXT_RC = 3'h2;
    localparam logic [2:0] RCS_HOPT_XTAL_32K = 3'h3;
    localparam logic [2:0] RCS_HOPT_XTAL_12M = 3'h4;
    localparam logic [2:0] RCS_HOPT_XTAL_4M = 3'h5;

    // Divider select values (divide by 2**sel)
    localparam logic [2:0] RCS_SLOW_DIV_SEL = 3'h2;
    localparam logic [2:0] RCS_NF_MIN_SEL = 3'h2;

    // Oscillator control register
    localparam int RCS_OSC_CLOCK_MODE_SELECT_BIT = 2;
    localparam logic RCS_CLOCK_MODE_SELECT_RESET = 1'b0;

    // Watchdog control register
    localparam int RCS_WDT_CLEAR_BIT = 0;
    localparam int RCS_WDT_EN_BIT = 1;
    localparam logic RCS_WDT_EN_RESET = 1'b1;

    // Status register field positions
    localparam int RCS_ST_STATE_LSB = 0;
    localparam int RCS_ST_SYSRST_BIT = 2;
    localparam int RCS_ST_WDTF_BIT = 3;
    localparam int RCS_ST_EXTF_BIT = 4;
    localparam int RCS_ST_SRC_LSB = 5;
    localparam int RCS_ST_DIV_LSB = 7;
    localparam int RCS_ST_PIN_BIT = 10;

    // Clock source codes as seen in status
    localparam logic [1:0] RCS_SRC_FAST_RC = 2'h0;
    localparam logic [1:0] RCS_SRC_EXT = 2'h1;
    localparam logic [1:0] RCS_SRC_SLOW_RC = 2'h2;

    // Sequence timing, in slow RC periods, and the reset vector
    localparam int RCS_CFG_PERIODS = 2048;
    localparam int RCS_WDT_LIMIT = 4096;
    localparam logic [15:0] RCS_RESET_VECTOR = 16'h0000;

    typedef enum logic [1:0] {
        RCS_ST_PIN_WAIT = 2'b00,
        RCS_ST_INIT = 2'b01,
        RCS_ST_WARMUP = 2'b10,
        RCS_ST_RUN = 2'b11
    } rcs_state_t;

    // Terminal count of the instruction-rate divider
    function automatic logic [6:0] rcs_div_mask(input logic [2:0] sel);
        logic [7:0] p;
        p = 8'h01 << sel;
        return p[6:0] - 7'h01;
    endfunction

endpackage

// ==== design/rcs_sync3.sv ====
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/100ps
module rcs_sync3 (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic async_in, // Asynchronous input
    output logic level_out, // Filtered level
    output logic rise_out // One-cycle pulse on rising level
);
    logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
    logic level_next, rise_next;

    always_comb
    begin
        level_next = level_reg;
        if (s2_reg == s3_reg)
        begin
            level_next = s3_reg;
        end
        rise_next = level_next & ~level_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            rise_reg <= rise_next;
        end
    end

    assign level_out = level_reg;
    assign rise_out = rise_reg;
endmodule

// ==== design/rcs_divider.sv ====
// Instruction-rate divider: counts source edges, ticks every 2**sel edges.
// Assumes src_edge is a one-cycle pulse per source period.
`timescale 1ns/100ps
module rcs_divider
    import rcs_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic run, // Tick allowed
    input wire logic src_edge, // Selected source edge
    input wire logic [2:0] div_sel, // Divide by 2**div_sel
    output logic tick // One-cycle instruction tick
);
    logic [6:0] cnt_reg, cnt_next;
    logic tick_reg, tick_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (src_edge)
        begin
            if (cnt_reg >= rcs_div_mask(div_sel))
            begin
                cnt_next = 7'h00;
                tick_next = run;
            end
            else
            begin
                cnt_next = cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ==== design/rcs_reset_clock_ctrl.sv ====
// Reset sequencer, watchdog and system clock source selection with an APB slave.
// Assumes oscillator outputs and the reset pin arrive asynchronously on input pins.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
module rcs_reset_clock_ctrl
    import rcs_pkg::*;
#(
    parameter int CFG_PERIODS = RCS_CFG_PERIODS,
    parameter int WDT_LIMIT = RCS_WDT_LIMIT,
    parameter int WDT_W = 16
)
(
    input wire logic CORE_CLK, // Core clock, 10 MHz
    input wire logic RESET, // Synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic RESET_PIN_N, // External reset pin, active low
    input wire logic FAST_RC_CLK, // Internal fast RC oscillator output
    input wire logic EXT_OSC_CLK, // External oscillator output
    input wire logic SLOW_RC_CLK, // Internal slow RC oscillator output
    output logic SYS_RESET, // System held in reset
    output logic SYS_INIT, // Pulse: load initial register values
    output logic FETCH_START, // Pulse: start fetching
    output logic [15:0] FETCH_ADDR, // First fetch address
    output logic CPU_TICK, // Pulse: one instruction cycle
    output logic [1:0] CLK_SOURCE // Selected system clock source
);
    rcs_state_t state_reg, state_next;
    rcs_cfg_t cfg_reg, cfg_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [WDT_W-1:0] wdt_reg, wdt_next;
    logic clock_mode_select_reg, clock_mode_select_next;
    logic wdt_en_reg, wdt_en_next;
    logic wdt_flag_reg, wdt_flag_next;
    logic ext_flag_reg, ext_flag_next;
    logic sys_reset_reg, sys_reset_next;
    logic sys_init_reg, sys_init_next;
    logic fetch_start_reg, fetch_start_next;
    logic [15:0] fetch_addr_reg, fetch_addr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [1:0] src_reg, src_next;
    logic pin_level, fast_edge, ext_edge, slow_edge;
    logic ext_hold, wdt_over, wdt_clear, running;
    logic apb_wr, apb_setup, addr_ok;
    logic src_edge;
    logic [2:0] div_eff;
    logic div_tick;

    rcs_sync3 u_pin_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .async_in(RESET_PIN_N),
        .level_out(pin_level),
        .rise_out()
    );

    rcs_sync3 u_fast_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .async_in(FAST_RC_CLK),
        .level_out(),
        .rise_out(fast_edge)
    );

    rcs_sync3 u_ext_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .async_in(EXT_OSC_CLK),
        .level_out(),
        .rise_out(ext_edge)
    );

    rcs_sync3 u_slow_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .async_in(SLOW_RC_CLK),
        .level_out(),
        .rise_out(slow_edge)
    );

    // APB decode
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr = PSEL & PENABLE & PWRITE;
    assign addr_ok = (PADDR == RCS_OFF_CONFIG) | (PADDR == RCS_OFF_OSC) | (PADDR == RCS_OFF_WDT)
        | (PADDR == RCS_OFF_STATUS) | (PADDR == RCS_OFF_WDT_COUNT);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // Pin held low with the pin enabled forces reset in any state
    assign ext_hold = cfg_reg.reset_pin_en & ~pin_level;
    assign running = (state_reg == RCS_ST_RUN);
    assign wdt_clear = apb_wr & (PADDR == RCS_OFF_WDT) & PWDATA[RCS_WDT_CLEAR_BIT];
    assign wdt_over = running & wdt_en_reg & slow_edge & ~wdt_clear
        & (wdt_reg == WDT_W'(WDT_LIMIT - 1));

    // Source selection and divider setting
    always_comb
    begin
        src_next = RCS_SRC_FAST_RC;
        div_eff = cfg_reg.div_sel;
        src_edge = fast_edge;
        if (clock_mode_select_reg)
        begin
            src_next = RCS_SRC_SLOW_RC;
            src_edge = slow_edge;
            div_eff = RCS_SLOW_DIV_SEL;
        end
        else
        begin
            case (cfg_reg.high_clock_option_select)
                RCS_HOPT_FAST_RC, RCS_HOPT_FAST_RC_RTC:
                begin
                    src_next = RCS_SRC_FAST_RC;
                    src_edge = fast_edge;
                end
                default:
                begin
                    src_next = RCS_SRC_EXT;
                    src_edge = ext_edge;
                end
            endcase
            if (cfg_reg.noise_filter_en && (cfg_reg.div_sel < RCS_NF_MIN_SEL))
            begin
                div_eff = RCS_NF_MIN_SEL;
            end
        end
    end

    // Tick only into a RUN cycle, never in the first reset cycle
    rcs_divider u_divider (
        .clk(CORE_CLK),
        .rst(RESET),
        .run(~sys_reset_next),
        .src_edge(src_edge),
        .div_sel(div_eff),
        .tick(div_tick)
    );

    // Reset sequencer
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        fetch_addr_next = fetch_addr_reg;
        if (ext_hold)
        begin
            state_next = RCS_ST_PIN_WAIT;
            cnt_next = 16'h0000;
        end
        else
        begin
            case (state_reg)
                RCS_ST_PIN_WAIT:
                begin
                    state_next = RCS_ST_INIT;
                end
                RCS_ST_INIT:
                begin
                    fetch_addr_next = RCS_RESET_VECTOR;
                    cnt_next = 16'h0000;
                    state_next = RCS_ST_WARMUP;
                end
                RCS_ST_WARMUP:
                begin
                    if (slow_edge)
                    begin
                        if (cnt_reg == 16'(CFG_PERIODS - 1))
                        begin
                            state_next = RCS_ST_RUN;
                            cnt_next = 16'h0000;
                        end
                        else
                        begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                RCS_ST_RUN:
                begin
                    if (wdt_over)
                    begin
                        state_next = RCS_ST_PIN_WAIT;
                    end
                end
                default:
                begin
                    state_next = RCS_ST_PIN_WAIT;
                end
            endcase
        end
        sys_reset_next = (state_next != RCS_ST_RUN);
        sys_init_next = (state_next == RCS_ST_INIT);
        fetch_start_next = (state_next == RCS_ST_RUN) & ~running;
    end

    // Watchdog counter
    always_comb
    begin
        wdt_next = wdt_reg;
        if (!running || wdt_clear || !wdt_en_reg)
        begin
            wdt_next = '0;
        end
        else if (slow_edge)
        begin
            if (wdt_over)
            begin
                wdt_next = '0;
            end
            else
            begin
                wdt_next = wdt_reg + WDT_W'(1);
            end
        end
    end

    // Software-visible registers
    always_comb
    begin
        cfg_next = cfg_reg;
        clock_mode_select_next = clock_mode_select_reg;
        wdt_en_next = wdt_en_reg;
        wdt_flag_next = wdt_flag_reg;
        ext_flag_next = ext_flag_reg;
        if (apb_wr)
        begin
            case (PADDR)
                RCS_OFF_CONFIG:
                begin
                    cfg_next = rcs_cfg_t'(PWDATA[7:0]);
                end
                RCS_OFF_OSC:
                begin
                    clock_mode_select_next = PWDATA[RCS_OSC_CLOCK_MODE_SELECT_BIT];
                end
                RCS_OFF_WDT:
                begin
                    wdt_en_next = PWDATA[RCS_WDT_EN_BIT];
                end
                RCS_OFF_STATUS:
                begin
                    if (PWDATA[RCS_ST_WDTF_BIT])
                    begin
                        wdt_flag_next = 1'b0;
                    end
                    if (PWDATA[RCS_ST_EXTF_BIT])
                    begin
                        ext_flag_next = 1'b0;
                    end
                end
                default:
                begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
        // Events win over a clear in the same cycle
        if (wdt_over)
        begin
            wdt_flag_next = 1'b1;
        end
        if (ext_hold && running)
        begin
            ext_flag_next = 1'b1;
        end
        // Mode select and watchdog enable return to initial values during the sequence
        if (!running)
        begin
            clock_mode_select_next = RCS_CLOCK_MODE_SELECT_RESET;
            wdt_en_next = RCS_WDT_EN_RESET;
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        prdata_next = prdata_reg;
        if (apb_setup && !PWRITE)
        begin
            prdata_next = 32'h00000000;
            case (PADDR)
                RCS_OFF_CONFIG:
                begin
                    prdata_next[7:0] = cfg_reg;
                end
                RCS_OFF_OSC:
                begin
                    prdata_next[RCS_OSC_CLOCK_MODE_SELECT_BIT] = clock_mode_select_reg;
                end
                RCS_OFF_WDT:
                begin
                    prdata_next[RCS_WDT_EN_BIT] = wdt_en_reg;
                end
                RCS_OFF_STATUS:
                begin
                    prdata_next[RCS_ST_STATE_LSB +: 2] = state_reg;
                    prdata_next[RCS_ST_SYSRST_BIT] = sys_reset_reg;
                    prdata_next[RCS_ST_WDTF_BIT] = wdt_flag_reg;
                    prdata_next[RCS_ST_EXTF_BIT] = ext_flag_reg;
                    prdata_next[RCS_ST_SRC_LSB +: 2] = src_reg;
                    prdata_next[RCS_ST_DIV_LSB +: 3] = div_eff;
                    prdata_next[RCS_ST_PIN_BIT] = pin_level;
                end
                RCS_OFF_WDT_COUNT:
                begin
                    prdata_next[WDT_W-1:0] = wdt_reg;
                end
                default:
                begin
                    prdata_next = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            state_reg <= RCS_ST_PIN_WAIT;
            cnt_reg <= 16'h0000;
            wdt_reg <= '0;
            cfg_reg <= RCS_CFG_RESET;
            clock_mode_select_reg <= RCS_CLOCK_MODE_SELECT_RESET;
            wdt_en_reg <= RCS_WDT_EN_RESET;
            wdt_flag_reg <= 1'b0;
            ext_flag_reg <= 1'b0;
            sys_reset_reg <= 1'b1;
            sys_init_reg <= 1'b0;
            fetch_start_reg <= 1'b0;
            fetch_addr_reg <= RCS_RESET_VECTOR;
            prdata_reg <= 32'h00000000;
            src_reg <= RCS_SRC_FAST_RC;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wdt_reg <= wdt_next;
            cfg_reg <= cfg_next;
            clock_mode_select_reg <= clock_mode_select_next;
            wdt_en_reg <= wdt_en_next;
            wdt_flag_reg <= wdt_flag_next;
            ext_flag_reg <= ext_flag_next;
            sys_reset_reg <= sys_reset_next;
            sys_init_reg <= sys_init_next;
            fetch_start_reg <= fetch_start_next;
            fetch_addr_reg <= fetch_addr_next;
            prdata_reg <= prdata_next;
            src_reg <= src_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign SYS_RESET = sys_reset_reg;
    assign SYS_INIT = sys_init_reg;
    assign FETCH_START = fetch_start_reg;
    assign FETCH_ADDR = fetch_addr_reg;
    assign CPU_TICK = div_tick;
    assign CLK_SOURCE = src_reg;
endmodule

// ==== testbench/rcs_ctrl_props.sv ====
// Concurrent checks on the ports of the reset and clock source controller.
// Assumes one core clock domain; bound to every instance of the controller.
`timescale 1ns/100ps
module rcs_ctrl_props
    import rcs_pkg::*;
#(
    parameter int CFG_PERIODS = RCS_CFG_PERIODS,
    parameter int WDT_LIMIT = RCS_WDT_LIMIT,
    parameter int WDT_W = 16
)
(
    input wire logic CORE_CLK, // Core clock
    input wire logic RESET, // Sync reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic PREADY, // APB ready
    input wire logic RESET_PIN_N, // Reset pin
    input wire logic SYS_RESET, // System in reset
    input wire logic SYS_INIT, // Init pulse
    input wire logic FETCH_START, // Fetch pulse
    input wire logic [15:0] FETCH_ADDR, // Fetch address
    input wire logic CPU_TICK, // Instruction tick
    input wire logic [1:0] CLK_SOURCE // Clock source
);
    logic cfg_en_reg;
    logic clock_mode_select_reg;
    logic [2:0] hopt_reg;
    logic [1:0] exp_src;
    logic wr;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    // Shadow of the option and mode bits from bus writes
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            cfg_en_reg <= RCS_CFG_RESET.reset_pin_en;
            hopt_reg <= RCS_CFG_RESET.high_clock_option_select;
            clock_mode_select_reg <= RCS_CLOCK_MODE_SELECT_RESET;
        end
        else
        begin
            if (wr && PADDR == RCS_OFF_CONFIG)
            begin
                cfg_en_reg <= PWDATA[0];
                hopt_reg <= PWDATA[3:1];
            end
            if (SYS_RESET)
                clock_mode_select_reg <= 1'b0;
            else if (wr && PADDR == RCS_OFF_OSC)
                clock_mode_select_reg <= PWDATA[RCS_OSC_CLOCK_MODE_SELECT_BIT];
        end
    end
    assign exp_src = clock_mode_select_reg ? RCS_SRC_SLOW_RC : ((hopt_reg <= 3'h1) ? RCS_SRC_FAST_RC : RCS_SRC_EXT);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    sequence init_step;
        SYS_INIT && SYS_RESET;
    endsequence
    sequence warm_step;
        !SYS_INIT && SYS_RESET && !FETCH_START;
    endsequence
    sequence pin_low;
        cfg_en_reg && !RESET_PIN_N;
    endsequence
    init_order_a: assert property (init_step |=> warm_step [*3])
        else $error("init not followed by warm-up");
    pin_hold_a: assert property (pin_low [*8] |-> SYS_RESET && !FETCH_START && !CPU_TICK)
        else $error("low pin did not hold reset");
    fetch_vector_a: assert property (FETCH_START |-> FETCH_ADDR == RCS_RESET_VECTOR)
        else $error("fetch address not zero");
    release_fetch_a: assert property ($fell(SYS_RESET) |-> FETCH_START)
        else $error("release without fetch start");
    fetch_single_a: assert property (FETCH_START |=> !FETCH_START && !SYS_RESET)
        else $error("fetch start not single");
    tick_run_a: assert property (CPU_TICK |-> !SYS_RESET)
        else $error("tick during reset");
    tick_pulse_a: assert property (CPU_TICK |=> !CPU_TICK)
        else $error("tick longer than one cycle");
    src_select_a: assert property ($stable(exp_src) [*4] |-> CLK_SOURCE == exp_src)
        else $error("wrong clock source");
endmodule
bind rcs_reset_clock_ctrl rcs_ctrl_props #(.CFG_PERIODS(CFG_PERIODS), .WDT_LIMIT(WDT_LIMIT), .WDT_W(WDT_W))
    rcs_ctrl_props_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .RESET_PIN_N(RESET_PIN_N), .SYS_RESET(SYS_RESET),
    .SYS_INIT(SYS_INIT), .FETCH_START(FETCH_START), .FETCH_ADDR(FETCH_ADDR), .CPU_TICK(CPU_TICK),
    .CLK_SOURCE(CLK_SOURCE));

// ==== testbench/rcs_reset_src.sv ====
// Behavioural external reset circuit driving the active-low reset pin.
// Assumes the bench commands when the pin is pulled low after power-up.
`timescale 1ns/100ps
module rcs_reset_src #(
    parameter int POR_CYCLES = 6
)
(
    input wire logic clk, // Core clock
    input wire logic hold_low, // Pull the pin low
    output logic reset_pin_n // Reset pin, active low
);
    int age = 0;
    initial reset_pin_n = 1'b0;
    // Power-up hold, then follow the command
    always @(posedge clk)
    begin
        if (age < POR_CYCLES)
            age <= age + 1;
        reset_pin_n <= !hold_low && age >= POR_CYCLES;
    end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the reset and clock source controller.
// Assumes slow stand-in oscillators and shortened warm-up and watchdog counts.
`timescale 1ns/100ps
module tb;
    import rcs_pkg::*;
    localparam int PF = 8;
    localparam int PE = 12;
    localparam int PS = 10;
    localparam int CFG = 4;
    logic CORE_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, hold_low = 1'b1;
    logic FAST_RC_CLK = 1'b0, EXT_OSC_CLK = 1'b0, SLOW_RC_CLK = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, d;
    logic RESET_PIN_N, PREADY, PSLVERR, SYS_RESET, SYS_INIT, FETCH_START, CPU_TICK, er, nf;
    logic [15:0] FETCH_ADDR;
    logic [1:0] CLK_SOURCE;
    logic [2:0] hopt;
    int miscompares = 0, samples_checked = 0, cyc = 0, seed = 32'h60EF95A4;
    int n, g, eff;
    rcs_reset_src rcs_reset_src_i (.clk(CORE_CLK), .hold_low(hold_low), .reset_pin_n(RESET_PIN_N));
    rcs_reset_clock_ctrl #(.CFG_PERIODS(CFG), .WDT_LIMIT(8)) rcs_reset_clock_ctrl_i (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RESET_PIN_N(RESET_PIN_N),
        .FAST_RC_CLK(FAST_RC_CLK), .EXT_OSC_CLK(EXT_OSC_CLK), .SLOW_RC_CLK(SLOW_RC_CLK), .SYS_RESET(SYS_RESET),
        .SYS_INIT(SYS_INIT), .FETCH_START(FETCH_START), .FETCH_ADDR(FETCH_ADDR), .CPU_TICK(CPU_TICK),
        .CLK_SOURCE(CLK_SOURCE));
    always #50 CORE_CLK = ~CORE_CLK;
    // Stand-in oscillators, slow enough for the input synchronisers
    always @(posedge CORE_CLK)
    begin
        cyc <= cyc + 1;
        FAST_RC_CLK <= (cyc % PF) < PF / 2;
        EXT_OSC_CLK <= (cyc % PE) < PE / 2;
        SLOW_RC_CLK <= (cyc % PS) < PS / 2;
        if (cyc == 40000)
        begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= dat;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CORE_CLK);
        while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wait_tick();
        do
            @(posedge CORE_CLK);
        while (CPU_TICK !== 1'b1);
    endtask
    // First interval after a change is skipped
    task automatic tick_gap(output int gap);
        int t;
        wait_tick();
        wait_tick();
        t = cyc;
        wait_tick();
        gap = cyc - t;
    endtask
    // Release the pin, follow start-up, then stop the watchdog
    task automatic boot();
        hold_low <= 1'b0;
        do
            @(posedge CORE_CLK);
        while (SYS_INIT !== 1'b1);
        n = 0;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (FETCH_START !== 1'b1);
        chk(n > (CFG - 1) * PS && n <= CFG * PS + 8, 1'b1);
        chk(FETCH_ADDR, 16'h0000);
        apb(1'b1, RCS_OFF_WDT, 32'h0);
    endtask
    initial
    begin
        repeat (2) @(posedge CORE_CLK);
        RESET <= 1'b0;
        apb(1'b0, RCS_OFF_CONFIG, 32'h0);
        chk(rd, 32'h41);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        repeat (20) @(posedge CORE_CLK);
        chk(SYS_RESET, 1'b1);
        apb(1'b0, RCS_OFF_STATUS, 32'h0);
        chk(rd[1:0], 2'h0);
        boot();
        apb(1'b0, RCS_OFF_WDT_COUNT, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            hopt = 3'(i % 6);
            nf = 1'($random(seed));
            d = $random(seed);
            d[7:0] = {3'(i), nf, hopt, 1'b1};
            apb(1'b1, RCS_OFF_CONFIG, d);
            apb(1'b0, RCS_OFF_CONFIG, 32'h0);
            chk(rd, {24'h0, d[7:0]});
            eff = (nf && i < 2) ? 2 : i;
            tick_gap(g);
            chk(g, ((hopt < 3'h2) ? PF : PE) << eff);
            chk(CLK_SOURCE, (hopt < 3'h2) ? RCS_SRC_FAST_RC : RCS_SRC_EXT);
        end
        apb(1'b1, RCS_OFF_OSC, 32'h4);
        tick_gap(g);
        chk(g, PS * 4);
        chk(CLK_SOURCE, RCS_SRC_SLOW_RC);
        apb(1'b1, RCS_OFF_WDT, 32'h2);
        repeat (4)
        begin
            repeat (40) @(posedge CORE_CLK);
            apb(1'b1, RCS_OFF_WDT, 32'h3);
        end
        chk(SYS_RESET, 1'b0);
        boot();
        apb(1'b0, RCS_OFF_STATUS, 32'h0);
        chk(rd[3], 1'b1);
        apb(1'b0, RCS_OFF_OSC, 32'h0);
        chk(rd, 32'h0);
        hold_low <= 1'b1;
        repeat (12) @(posedge CORE_CLK);
        chk(SYS_RESET, 1'b1);
        apb(1'b0, RCS_OFF_STATUS, 32'h0);
        chk(rd[4], 1'b1);
        boot();
        apb(1'b1, RCS_OFF_CONFIG, 32'h40);
        hold_low <= 1'b1;
        repeat (30) @(posedge CORE_CLK);
        chk(SYS_RESET, 1'b0);
        apb(1'b0, RCS_OFF_STATUS, 32'h0);
        chk(rd[1:0], 2'h3);
        end_sim();
    end
endmodule
